// ---- logic/scs_pkg.sv ----
package scs_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_STATUS_A = 8'h08;
	localparam logic [7:0] OFF_BIT_RATE = 8'h0c;
	localparam logic [7:0] OFF_FIFO_DATA = 8'h10;
	localparam logic [31:0] RST_CTRL_A = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL_B = 32'h0000_0000;
	localparam logic [31:0] RST_BIT_RATE = 32'h0000_0000;
	// ==========================================================
	// status a and interrupt enable layout (same bit positions)
	localparam int ST_DRDY = 0;
	localparam int ST_BC = 1;
	localparam int ST_OVER = 2;
	localparam int ST_PE = 3;
	localparam int ST_FE = 4;
	localparam int ST_BRK = 5;
	localparam int ST_NFLAGS = 6;
	localparam int ST_NBYTES_LSB = 8;
	// ==========================================================
	// control a / control b fields
	localparam int CA_CE = 31;
	localparam int CA_DMA = 30;
	localparam int CA_LEN_LSB = 16;
	localparam int CB_MODE_LSB = 20;
	localparam logic [1:0] MODE_MASTER = 2'h2;
	localparam logic [1:0] MODE_SLAVE = 2'h3;
	// ==========================================================
	// bit rate fields
	localparam int BR_RATE_EN = 31;
	localparam int BR_DIV_LSB = 0;
	localparam int BR_DIV_W = 8;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SCS_IDLE, SCS_MASTER, SCS_SLAVE} scs_state_t;
endpackage : scs_pkg

// ---- logic/scs_sync.sv ----
`timescale 1ns/1ns
module scs_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// two flop synchroniser, first stage read only by the second
	logic [W-1:0] meta_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : scs_sync

// ---- logic/scs_flag.sv ----
`timescale 1ns/1ns
module scs_flag (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	// ==========================================================
	// sticky flag, a set in the clearing cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end
endmodule : scs_flag

// ---- logic/scs_top.sv ----
// Summary of operation
// - master sets byte count, shifts both ways
// - master drives the one serial clock
// - data moves only while select low
// - master drives select for each slave; the design has one select output, spi_sel_n_o
// - break flag sticky until one written
// - framing error flag sticky, one clears
// - parity error flag sticky, one clears
// - overrun when storing into full buffer
// - each status interrupt gated by enable
// - data ready plus valid byte count
// - data ready never with buffer closed
// - dma mode clears buffer closed itself
// - master pins: clock, select, txd out
// - slave pins: clock, select, rxd in
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module scs_top import scs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic spi_txd,
	input wire logic spi_rxd,
	input wire logic spi_clk_i,
	output logic spi_clk_o,
	output logic spi_clk_oe,
	input wire logic spi_sel_n_i,
	output logic spi_sel_n_o,
	output logic spi_sel_n_oe,
	input wire logic rx_break_evt,
	input wire logic rx_parity_evt,
	output logic dma_req,
	input wire logic dma_ack,
	output logic irq
);
	// ==========================================================
	// bus slave
	logic aw_got_r, w_got_r, do_wr, rd_hs;
	logic [ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] ctrl_a_r, ctrl_b_r, bit_rate_r, rd_val, status_a, wmask;
	logic rd_err;
	assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
	assign rd_hs = s_axi_arvalid && s_axi_arready;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			aw_got_r <= 1'b0;
			waddr_r <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_got_r <= 1'b1;
			waddr_r <= s_axi_awaddr;
		end
		else
		begin
			if (do_wr)
				aw_got_r <= 1'b0;
			s_axi_awready <= !aw_got_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
			w_got_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_got_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		else
		begin
			if (do_wr)
				w_got_r <= 1'b0;
			s_axi_wready <= !w_got_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (do_wr)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (waddr_r > OFF_FIFO_DATA || waddr_r[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_a_r <= RST_CTRL_A;
			ctrl_b_r <= RST_CTRL_B;
			bit_rate_r <= RST_BIT_RATE;
		end
		else if (do_wr)
		begin
			if (waddr_r == OFF_CTRL_A)
				ctrl_a_r <= (ctrl_a_r & ~wmask) | (wdata_r & wmask);
			if (waddr_r == OFF_CTRL_B)
				ctrl_b_r <= (ctrl_b_r & ~wmask) | (wdata_r & wmask);
			if (waddr_r == OFF_BIT_RATE)
				bit_rate_r <= (bit_rate_r & ~wmask) | (wdata_r & wmask);
		end
	end

	logic ce, dma_en, slave_sel, master_sel, data_wr, data_rd, pop;
	logic [1:0] len;
	assign ce = ctrl_a_r[CA_CE];
	assign dma_en = ctrl_a_r[CA_DMA];
	assign len = ctrl_a_r[CA_LEN_LSB +: 2];
	assign slave_sel = ce && ctrl_b_r[CB_MODE_LSB +: 2] == MODE_SLAVE;
	assign master_sel = ce && bit_rate_r[BR_RATE_EN] && ctrl_b_r[CB_MODE_LSB +: 2] == MODE_MASTER;
	assign data_wr = do_wr && waddr_r == OFF_FIFO_DATA;
	assign data_rd = rd_hs && s_axi_araddr == OFF_FIFO_DATA;
	assign pop = data_rd || (dma_en && dma_ack);

	// ==========================================================
	// pin synchronisers and edge detection
	logic clk_s, sel_act_s, sel_n_s, rxd_s, clk_d_r, sel_n_d_r;
	// select travels inverted so the synchroniser reset level matches the idle pin
	scs_sync #(.W(3)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({spi_clk_i, !spi_sel_n_i, spi_rxd}),
		.q({clk_s, sel_act_s, rxd_s})
	);
	assign sel_n_s = !sel_act_s;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			clk_d_r <= 1'b0;
			sel_n_d_r <= 1'b1;
		end
		else
		begin
			clk_d_r <= clk_s;
			sel_n_d_r <= sel_n_s;
		end
	end

	// ==========================================================
	// shift engine
	scs_state_t state_r;
	logic [BR_DIV_W-1:0] half_r;
	logic [5:0] bit_cnt_r, tot_bits_r;
	logic [31:0] tx_sh_r, rx_sh_r;
	logic m_tick, m_rise, m_done, s_rise, s_fall, s_end;
	logic store_ev, fe_ev, bc_ev;
	logic [31:0] store_word;
	logic [2:0] store_bytes;
	assign m_tick = state_r == SCS_MASTER && half_r == '0;
	assign m_rise = m_tick && !spi_clk_o;
	assign m_done = m_rise && bit_cnt_r + 6'h01 == tot_bits_r;
	assign s_rise = state_r == SCS_SLAVE && !sel_n_s && clk_s && !clk_d_r;
	assign s_fall = state_r == SCS_SLAVE && !sel_n_s && !clk_s && clk_d_r;
	assign s_end = state_r == SCS_SLAVE && sel_n_s && !sel_n_d_r;

	always_comb
	begin
		store_ev = 1'b0;
		store_word = {rx_sh_r[30:0], rxd_s};
		store_bytes = 3'h4;
		fe_ev = 1'b0;
		bc_ev = 1'b0;
		if (m_done)
		begin
			store_ev = 1'b1;
			store_bytes = {1'b0, len} + 3'h1;
			bc_ev = 1'b1;
		end
		else if (s_rise && bit_cnt_r == 6'h1f)
			store_ev = 1'b1;
		else if (s_end && bit_cnt_r != 6'h00)
		begin
			fe_ev = bit_cnt_r[2:0] != 3'h0;
			store_ev = bit_cnt_r[5:3] != 3'h0;
			store_word = rx_sh_r;
			store_bytes = {1'b0, bit_cnt_r[4:3]};
			bc_ev = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ce)
		begin
			state_r <= SCS_IDLE;
			half_r <= '0;
			bit_cnt_r <= '0;
			tot_bits_r <= '0;
			tx_sh_r <= '0;
			rx_sh_r <= '0;
			spi_txd <= 1'b0;
			spi_clk_o <= 1'b0;
			spi_sel_n_o <= 1'b1;
		end
		else
		begin
			case (state_r)
				SCS_IDLE:
				begin
					bit_cnt_r <= '0;
					if (data_wr)
					begin
						tx_sh_r <= wdata_r;
						spi_txd <= wdata_r[31];
					end
					if (data_wr && master_sel)
					begin
						state_r <= SCS_MASTER;
						tot_bits_r <= {1'b0, ({1'b0, len} + 3'h1), 2'h0} << 1;
						half_r <= bit_rate_r[BR_DIV_LSB +: BR_DIV_W];
						// select driven low for the frame
						spi_sel_n_o <= 1'b0;
					end
					else if (slave_sel)
						state_r <= SCS_SLAVE;
				end
				SCS_MASTER:
				begin
					half_r <= m_tick ? bit_rate_r[BR_DIV_LSB +: BR_DIV_W] : half_r - 1'b1;
					if (m_tick)
					begin
						spi_clk_o <= !spi_clk_o;
						if (m_rise)
						begin
							rx_sh_r <= store_word;
							bit_cnt_r <= bit_cnt_r + 6'h01;
						end
						// end on the fall after the last rise: clock idles low
						// and select rises in the same cycle as that last clock fall
						else if (bit_cnt_r == tot_bits_r)
						begin
							state_r <= SCS_IDLE;
							spi_sel_n_o <= 1'b1;
						end
						else
						begin
							tx_sh_r <= {tx_sh_r[30:0], 1'b0};
							spi_txd <= tx_sh_r[30];
						end
					end
				end
				SCS_SLAVE:
				begin
					if (!slave_sel)
						state_r <= SCS_IDLE;
					if (s_rise)
					begin
						rx_sh_r <= store_word;
						bit_cnt_r <= bit_cnt_r == 6'h1f ? 6'h00 : bit_cnt_r + 6'h01;
					end
					if (s_fall)
					begin
						tx_sh_r <= {tx_sh_r[30:0], 1'b0};
						spi_txd <= tx_sh_r[30];
					end
					if (s_end)
						bit_cnt_r <= '0;
					if (data_wr && sel_n_s)
					begin
						tx_sh_r <= wdata_r;
						spi_txd <= wdata_r[31];
					end
				end
				default:
					state_r <= SCS_IDLE;
			endcase
		end
	end

	// ==========================================================
	// pin directions: master drives clock and select, slave listens
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			spi_clk_oe <= 1'b0;
			spi_sel_n_oe <= 1'b0;
		end
		else
		begin
			spi_clk_oe <= master_sel;
			spi_sel_n_oe <= master_sel;
		end
	end

	// ==========================================================
	// receive holding word, one deep as the rules need no more
	logic rx_full_r;
	logic [31:0] rx_word_r;
	logic [2:0] rx_bytes_r;
	logic over_ev;
	assign over_ev = store_ev && rx_full_r && !pop;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_full_r <= 1'b0;
			rx_word_r <= '0;
			rx_bytes_r <= '0;
		end
		else if (store_ev && !over_ev)
		begin
			rx_full_r <= 1'b1;
			rx_word_r <= store_word;
			rx_bytes_r <= store_bytes;
		end
		else if (pop)
			rx_full_r <= 1'b0;
	end

	// ==========================================================
	// sticky status flags
	logic st_wr;
	logic [ST_NFLAGS-1:0] flag_set, flag_clr, flags;
	assign st_wr = do_wr && waddr_r == OFF_STATUS_A && wstrb_r[0];
	assign flag_clr = st_wr ? wdata_r[ST_NFLAGS-1:0] : '0;
	always_comb
	begin
		flag_set = '0;
		flag_set[ST_BRK] = rx_break_evt;
		flag_set[ST_FE] = fe_ev;
		flag_set[ST_PE] = rx_parity_evt;
		flag_set[ST_OVER] = over_ev;
		flag_set[ST_BC] = bc_ev;
	end
	genvar gi;
	generate
		for (gi = ST_BC; gi < ST_NFLAGS; gi++)
		begin : g_flag
			if (gi == ST_BC)
			begin : g_bc
				scs_flag u_flag (
					.aclk(aclk),
					.aresetn(aresetn),
					.set(flag_set[gi]),
					.clr(flag_clr[gi] || (dma_en && flags[gi])),
					.q(flags[gi])
				);
			end
			else
			begin : g_std
				scs_flag u_flag (
					.aclk(aclk),
					.aresetn(aresetn),
					.set(flag_set[gi]),
					.clr(flag_clr[gi]),
					.q(flags[gi])
				);
			end
		end
	endgenerate
	// ready while the word is held and buffer closed is clear
	assign flags[ST_DRDY] = rx_full_r && !flags[ST_BC];
	always_comb
	begin
		status_a = '0;
		status_a[ST_NFLAGS-1:0] = flags;
		status_a[ST_NBYTES_LSB +: 3] = rx_bytes_r;
	end

	// ==========================================================
	// read path
	always_comb
	begin
		rd_val = '0;
		rd_err = 1'b0;
		case (s_axi_araddr)
			OFF_CTRL_A: rd_val = ctrl_a_r;
			OFF_CTRL_B: rd_val = ctrl_b_r;
			OFF_STATUS_A: rd_val = status_a;
			OFF_BIT_RATE: rd_val = bit_rate_r;
			OFF_FIFO_DATA: rd_val = rx_word_r;
			default: rd_err = 1'b1;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rd_hs)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			s_axi_arready <= !s_axi_rvalid || s_axi_rready;
		end
	end

	// ==========================================================
	// interrupt and dma request
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq <= 1'b0;
			dma_req <= 1'b0;
		end
		else
		begin
			irq <= |(flags & ctrl_a_r[ST_NFLAGS-1:0]);
			dma_req <= dma_en && rx_full_r && !pop;
		end
	end

	// ==========================================================
	// checks
	chk_ready_closed_excl: assert property (@(posedge aclk) disable iff (!aresetn)
		!(flags[ST_DRDY] && flags[ST_BC])) else $error("data ready with buffer closed");
	chk_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 irq == |($past(flags) & $past(ctrl_a_r[ST_NFLAGS-1:0])))
		else $error("interrupt does not follow enabled flags");
	chk_slave_sel_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == SCS_SLAVE && sel_n_s && ce) |=> $stable(rx_sh_r))
		else $error("slave shifted with select high");
	chk_master_sel_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == SCS_MASTER) |-> !spi_sel_n_o) else $error("select high in frame");
	chk_frame_length: assert property (@(posedge aclk) disable iff (!aresetn)
		m_done |-> bit_cnt_r == {1'b0, len, 3'h7})
		else $error("frame length differs from byte count");
	chk_break_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(flags[ST_BRK] && !flag_clr[ST_BRK]) |=> flags[ST_BRK]) else $error("break lost");
	chk_framing_set: assert property (@(posedge aclk) disable iff (!aresetn)
		fe_ev |=> flags[ST_FE]) else $error("framing error not flagged");
	chk_parity_set: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_parity_evt |=> flags[ST_PE]) else $error("parity error not flagged");
	chk_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(store_ev && rx_full_r && !pop) |=> flags[ST_OVER] && $stable(rx_word_r))
		else $error("overrun not flagged");
	chk_dma_interlock: assert property (@(posedge aclk) disable iff (!aresetn)
		(dma_en && flags[ST_BC] && !bc_ev) |=> !flags[ST_BC]) else $error("dma interlock stuck");
	chk_master_clk_out: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == SCS_MASTER) |-> spi_clk_oe) else $error("master clock not driven");
	chk_zero_write_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_wr && !wdata_r[ST_OVER] && flags[ST_OVER]) |=> flags[ST_OVER])
		else $error("zero write cleared flag");
endmodule : scs_top

// ---- tb/scs_spi_slave_model.sv ----
`timescale 1ns/1ns
module scs_spi_slave_model (
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic mosi,
	input wire logic [31:0] tx_word,
	output logic miso,
	output logic [31:0] rx_word
);
	logic [31:0] sh;
	initial
	begin
		sh = 32'h0;
		miso = 1'b1;
		rx_word = 32'h0;
	end
	// ==========================================================
	// framing
	// bits move only while selected
	always @(negedge sel_n)
	begin
		sh = tx_word;
		miso = sh[31];
	end
	// released line shows the inverse, so a stale bit never passes
	always @(posedge sel_n)
		miso = ~miso;
	always @(posedge sclk)
		if (!sel_n)
			rx_word = {rx_word[30:0], mosi};
	// next bit on fall while selected
	always @(negedge sclk)
		if (!sel_n)
		begin
			sh = {sh[30:0], 1'b0};
			miso = sh[31];
		end
endmodule : scs_spi_slave_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	import scs_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, slv_tx, slv_rx, d;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid;
	logic txd, rxd, clk_o, clk_oe, sel_o, sel_oe, brk, par, dreq, dack, irq;
	logic ext_clk, ext_sel_n, ext_mosi;
	int n_mismatch, checks_done, cyc;
	scs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .spi_txd(txd), .spi_rxd(ext_sel_n ? rxd : ext_mosi),
		.spi_clk_i(ext_clk),
		.spi_clk_o(clk_o), .spi_clk_oe(clk_oe), .spi_sel_n_i(ext_sel_n),
		.spi_sel_n_o(sel_o), .spi_sel_n_oe(sel_oe), .rx_break_evt(brk),
		.rx_parity_evt(par), .dma_req(dreq), .dma_ack(dack), .irq(irq));
	scs_spi_slave_model slv (.sclk(clk_o), .sel_n(sel_o), .mosi(txd),
		.tx_word(slv_tx), .miso(rxd), .rx_word(slv_rx));
	// ==========================================================
	// clock, reset, timeout
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// ceiling: a handful of 32-bit frames at 40 cycles per bit
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// bus tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd
	task automatic st(input logic [5:0] e);
		rd(OFF_STATUS_A, d);
		chk("status", {26'h0, e}, {26'h0, d[5:0]});
	endtask : st
	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask : wait_n
	task automatic pulse(input bit b);
		@(posedge aclk);
		if (b)
			brk <= 1'b1;
		else
			par <= 1'b1;
		@(posedge aclk);
		brk <= 1'b0;
		par <= 1'b0;
	endtask : pulse
	task automatic frame(input logic [31:0] dw, input logic [31:0] sw);
		slv_tx = sw;
		wr(OFF_FIFO_DATA, dw);
		while (sel_o)
			@(posedge aclk);
		wait_n(2);
		chk("pins", 32'h6, {29'h0, clk_oe, sel_oe, sel_o});
		while (!sel_o)
			@(posedge aclk);
		wait_n(3);
		chk("slave_rx", dw, slv_rx);
	endtask : frame
	// external master for slave mode, link clock 160 ns, idles low
	task automatic ext_frame(input logic [31:0] v, input int nb, output logic [31:0] got);
		got = 32'h0;
		ext_sel_n <= 1'b0;
		for (int i = nb - 1; i >= 0; i--)
		begin
			ext_mosi <= v[i];
			wait_n(20);
			ext_clk <= 1'b1;
			got = {got[30:0], txd};
			wait_n(20);
			ext_clk <= 1'b0;
		end
		wait_n(20);
		ext_sel_n <= 1'b1;
		wait_n(20);
	endtask : ext_frame
	// ==========================================================
	// tests
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, brk, par, dack} = 8'h0;
		{ext_clk, ext_sel_n, ext_mosi} = 3'h2;
		{awaddr, araddr, wdata, slv_tx} = '0;
		{n_mismatch, checks_done, cyc} = '0;
		aresetn = 1'b0;
		wait_n(5);
		aresetn <= 1'b1;
		wait_n(2);
		rd(OFF_CTRL_A, d);
		chk("ctrl_a_rst", RST_CTRL_A, d);
		rd(OFF_CTRL_B, d);
		chk("ctrl_b_rst", RST_CTRL_B, d);
		rd(OFF_BIT_RATE, d);
		chk("rate_rst", RST_BIT_RATE, d);
		rd(8'h14, d);
		chk("unmapped_rd", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped_data", 32'h0, d);
		wr(8'h14, 32'h1);
		chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, r});
		// sticky flags, zero writes and masking
		wr(OFF_CTRL_A, 32'h0000_0020);
		pulse(1'b1);
		pulse(1'b0);
		st(6'h28);
		wr(OFF_STATUS_A, 32'h0);
		st(6'h28);
		wait_n(3);
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(OFF_STATUS_A, 32'h20);
		st(6'h08);
		wait_n(3);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(OFF_STATUS_A, 32'h08);
		st(6'h00);
		// master frames: 4 bytes, half period 20 cycles
		wr(OFF_CTRL_B, 32'h0020_0000);
		wr(OFF_BIT_RATE, 32'h8000_0013);
		wr(OFF_CTRL_A, 32'h8003_0000);
		frame(32'ha5c3_0f96, 32'h3c5a_e187);
		st(6'h02);
		wr(OFF_STATUS_A, 32'h02);
		st(6'h01);
		rd(OFF_STATUS_A, d);
		chk("byte_count", 32'h4, {29'h0, d[10:8]});
		frame(32'h0f1e_2d3c, 32'h1234_5678);
		st(6'h06);
		wr(OFF_STATUS_A, 32'h06);
		rd(OFF_FIFO_DATA, d);
		chk("rx_word", 32'h3c5a_e187, d);
		st(6'h00);
		// dma mode
		wr(OFF_CTRL_A, 32'hc003_0000);
		frame(32'h8001_7ffe, 32'hdead_0001);
		wait_n(2);
		chk("dma_req", 32'h1, {31'h0, dreq});
		st(6'h01);
		@(posedge aclk);
		dack <= 1'b1;
		@(posedge aclk);
		dack <= 1'b0;
		wait_n(3);
		chk("dma_pop", 32'h0, {31'h0, dreq});
		// slave setup order leaves the pins undriven
		wr(OFF_CTRL_A, 32'h0);
		wr(OFF_BIT_RATE, 32'h8000_0000);
		wr(OFF_CTRL_B, 32'h0030_0000);
		wr(OFF_CTRL_A, 32'h8000_0000);
		wait_n(3);
		chk("slave_pins", 32'h0, {30'h0, clk_oe, sel_oe});
		// slave frames from an external master; the clock first runs with select high
		wr(OFF_FIFO_DATA, 32'h5a0f_c396);
		repeat (4)
		begin
			ext_clk <= ~ext_clk;
			wait_n(20);
		end
		ext_frame(32'hc35a_9617, 32, d);
		chk("slave_txd", 32'h5a0f_c396, d);
		st(6'h01);
		rd(OFF_FIFO_DATA, d);
		chk("slave_word", 32'hc35a_9617, d);
		ext_frame(32'h0000_0abc, 12, d);
		st(6'h12);
		chk("slave_bytes", 32'h1, {29'h0, d[10:8]});
		tally_and_finish();
	end
endmodule : testbench
